// *** pkg/e1_alarm_pkg.sv ***
`default_nettype none

package e1_alarm_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] A_ALARM = 8'h06; // receive_alarm_status
    localparam logic [7:0] A_EVENT = 8'h07; // frame_event_status
    localparam logic [7:0] A_MASK1 = 8'h16; // mask for receive_alarm_status
    localparam logic [7:0] A_MASK2 = 8'h17; // mask for frame_event_status
    localparam logic [7:0] A_SYNC = 8'h1e; // sync search counter view
    localparam logic [7:0] A_CTRL = 8'h1f; // control bits
    localparam logic [7:0] MASK_RESET = 8'h00;

    // Control register fields
    localparam int CTL_CRC_EN = 0; // crc_mode_enable
    localparam int CTL_FAST = 1; // fast_interval_select
    localparam int CTL_EXT_LOSS = 2; // extended_loss_threshold
    localparam int CTL_PIN_EN = 3; // clock_loss_pin_enable

    // receive_alarm_status fields
    localparam int B_SA1 = 7;
    localparam int B_DMA = 6;
    localparam int B_SA0 = 5;
    localparam int B_RX_SLIP_FLAG = 4;
    localparam int B_UA1 = 3;
    localparam int B_RRA = 2;
    localparam int B_RCL = 1;
    localparam int B_LOS = 0;
    // Bits that interrupt on every state change rather than on assertion
    localparam logic [7:0] ALARM_KIND = 8'h0f;

    // frame_event_status fields
    localparam int E_RMF = 7;
    localparam int E_RAF = 6;
    localparam int E_TMF = 5;
    localparam int E_SEC = 4;
    localparam int E_TAF = 3;
    localparam int E_TX_CLOCK_LOSS_FLAG = 2;
    localparam int E_RX_CRC_MF_FLAG = 1;
    localparam int E_TX_SLIP_FLAG = 0;

    // ----------------------------------------------------------------
    // Detector thresholds
    // ----------------------------------------------------------------
    localparam int DMA_BIT = 2; // bit 6 of the slot, counting 1 at the MSB
    localparam logic [3:0] MF_LAST = 4'hf; // 16 frames per multiframe
    localparam logic [1:0] MIN_ZEROS = 2'h3; // fewer than three zeros
    localparam logic [8:0] UA1_WIN_LAST = 9'h1ff; // 512-bit window
    localparam logic [1:0] RRA_RUN = 2'h3; // three consecutive occasions
    localparam logic [11:0] RCL_ZEROS = 12'h0ff; // 255 zeros
    localparam logic [11:0] RCL_ZEROS_EXT = 12'h800; // 2048 zeros
    localparam logic [7:0] RCL_WIN_LAST = 8'hfe; // 255-bit clear window
    localparam logic [5:0] RCL_ONES = 6'h20; // 32 ones to clear

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int CHANNEL_TIME_NS = 3906; // one channel time, 8 bits
    localparam int TX_CLOCK_LOSS_FLAG_CYCLES = CHANNEL_TIME_NS / CLK_PERIOD_NS; // rounds down
    localparam logic [5:0] TX_CLOCK_LOSS_FLAG_LAST = 6'(TX_CLOCK_LOSS_FLAG_CYCLES - 1);
    localparam int SEC_BITS = 2048000; // receive bits in one second
    localparam int FAST_BITS = 128000; // receive bits in 62.5 ms

endpackage

`default_nettype wire

// *** design/e1_alarm_status_monitor.sv ***
// How it works
// - Search counter adds one whenever an 8 ms multiframe search times out.
// - Search counter clears when multiframe sync is achieved.
// - Search counter clears while crc_mode_enable is zero.
// - Search counter wraps from its top value back to zero.
// - All-ones alarm: fewer than three zeros in slot 16 over 16 frames.
// - All-zeros alarm: slot 16 all zero over a full multiframe.
// - A signaling change sets both signaling flags together.
// - All-ones and distant alarms stay active in common-channel mode.
// - Distant alarm follows bit 6 of frame 0 slot 16 over two multiframes.
// - Receive and transmit slips set their slip flags.
// - Unframed all-ones: fewer than three zeros in a 512-bit window.
// - Remote alarm follows non-align bit 3 over three occasions.
// - Carrier loss after 255 or 2048 zeros; clears on 32 ones in 255.
// - Loss-of-sync flag held while the framer is out of sync.
// - Receive CAS multiframe flag set on every receive multiframe boundary.
// - Receive align-frame flag set at each received align frame.
// - Transmit align-frame flag set at each transmitted align frame.
// - Transmit multiframe flag set on every transmit multiframe boundary.
// - Timer flag each second of receive clock, or each 62.5 ms.
// - Transmit clock still for a channel time sets loss flag and pin.
// - CRC multiframe flag on boundaries, free-running every 16 frames if off.
// - Six-bit search counter readable with its bit 1 hidden.
// - Alarm bits 3-0 pull interrupt low on any change, bits 7-4 on being set, until read.
// - Event bits pull interrupt low on occurrence until read.
// - Only flags with their mask bit set reach the interrupt.
`default_nettype none

module e1_alarm_status_monitor #(
    parameter int SEC_BITS = e1_alarm_pkg::SEC_BITS,
    parameter int FAST_BITS = e1_alarm_pkg::FAST_BITS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    // Receive framer indications
    input wire logic rx_bit_stb,
    input wire logic rx_bit,
    input wire logic rx_frame_stb,
    input wire logic rx_align_stb,
    input wire logic rx_ts16_stb,
    input wire logic [7:0] rx_ts16_byte,
    input wire logic rx_ts16_frame0,
    input wire logic rx_nonalign_stb,
    input wire logic rx_remote_bit,
    input wire logic rx_in_sync,
    input wire logic sig_change_stb,
    input wire logic rx_cas_mf_stb,
    input wire logic rx_crc_mf_stb,
    input wire logic crc_search_timeout_stb,
    input wire logic crc_sync_stb,
    input wire logic rx_slip_stb,
    // Transmit side indications
    input wire logic tx_line_clock,
    input wire logic tx_align_stb,
    input wire logic tx_mf_stb,
    input wire logic tx_slip_stb,
    // Outputs
    output logic int_n,
    output logic clock_loss_pin
);

    localparam int SEC_W = $clog2(SEC_BITS);
    localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SEC_BITS - 1);
    localparam logic [SEC_W-1:0] FAST_LAST = SEC_W'(FAST_BITS - 1);

    // Counter widths are derived from SEC_BITS, so the fast interval must fit
    if (FAST_BITS < 2 || FAST_BITS > SEC_BITS) begin : g_bad_interval
        $error("FAST_BITS must lie between 2 and SEC_BITS");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] mask1;
        logic [7:0] mask2;
        logic [3:0] ctrl;
        logic [7:0] alarm_st;
        logic [7:0] event_st;
        logic [7:0] pend1;
        logic [7:0] pend2;
        logic [5:0] crc_cnt;
        logic [7:0] rd_data;
        logic int_n;
        logic loss_pin;
        logic los;
        logic [3:0] ts16_cnt;
        logic [1:0] sa_zeros;
        logic sa_one;
        logic sa1;
        logic sa0;
        logic dma_prev;
        logic dma;
        logic [8:0] ua1_cnt;
        logic [1:0] ua1_zeros;
        logic ua1;
        logic [1:0] rra_ones;
        logic [1:0] rra_zeros;
        logic remote_alarm_flag;
        logic [11:0] rcl_zeros;
        logic [7:0] rcl_win;
        logic [5:0] rcl_ones;
        logic carrier_loss_flag;
        logic [SEC_W-1:0] sec_cnt;
        logic [3:0] mf_cnt;
        logic tx_line_clock_prev;
        logic [5:0] tx_clock_loss_flag_cnt;
        logic tx_clock_loss_flag;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    localparam logic [1:0] MIN_ZEROS_I = e1_alarm_pkg::MIN_ZEROS;

    // Zero count saturating at three; only "fewer than three" matters
    function automatic logic [1:0] add_sat3(input logic [1:0] acc, input logic [3:0] n);
        logic [4:0] sum;
        sum = 5'(acc) + 5'(n);
        return (sum > 5'(MIN_ZEROS_I)) ? MIN_ZEROS_I : sum[1:0];
    endfunction

    function automatic logic [3:0] zeros_in(input logic [7:0] b);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 8; i++) begin
            c = c + {3'h0, ~b[i]};
        end
        return c;
    endfunction

    function automatic logic [1:0] run_inc(input logic [1:0] r);
        return (r == e1_alarm_pkg::RRA_RUN) ? r : r + 2'h1;
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic [7:0] set1;
        logic [7:0] irq1;
        logic [7:0] chg1;
        logic [7:0] set2;
        logic [7:0] irq2;
        logic [1:0] zacc;
        logic [11:0] rcl_thr;
        logic sec_tick;
        logic rx_crc_mf_flag_tick;
        logic rd_alarm;
        logic rd_event;
        set1 = 8'h00;
        irq1 = 8'h00;
        chg1 = 8'h00;
        set2 = 8'h00;
        irq2 = 8'h00;
        zacc = 2'h0;
        rcl_thr = 12'h000;
        sec_tick = 1'b0;
        rx_crc_mf_flag_tick = 1'b0;
        rd_alarm = rd_stb && (addr == e1_alarm_pkg::A_ALARM);
        rd_event = rd_stb && (addr == e1_alarm_pkg::A_EVENT);
        nxt_st = st_ff;

        // Multiframe search counter; wraps on its own six-bit width.
        // The write that turns the mode off clears it at once, so a read
        // straight after that write already sees zero.
        if (!st_ff.ctrl[e1_alarm_pkg::CTL_CRC_EN] || crc_sync_stb
            || (wr_stb && addr == e1_alarm_pkg::A_CTRL
            && !wr_data[e1_alarm_pkg::CTL_CRC_EN])) begin
            nxt_st.crc_cnt = 6'h00;
        end else if (crc_search_timeout_stb) begin
            nxt_st.crc_cnt = st_ff.crc_cnt + 6'h01;
        end

        // Slot 16 window over one multiframe, started at frame 0.
        // Nothing here looks at the signaling mode, so common-channel
        // operation leaves the detectors running.
        if (rx_ts16_stb) begin
            if (rx_ts16_frame0) begin
                nxt_st.ts16_cnt = 4'h1;
                nxt_st.sa_zeros = add_sat3(2'h0, zeros_in(rx_ts16_byte));
                nxt_st.sa_one = |rx_ts16_byte;
                if (rx_ts16_byte[e1_alarm_pkg::DMA_BIT] && st_ff.dma_prev) begin
                    nxt_st.dma = 1'b1;
                end else if (!rx_ts16_byte[e1_alarm_pkg::DMA_BIT] && !st_ff.dma_prev) begin
                    nxt_st.dma = 1'b0;
                end
                nxt_st.dma_prev = rx_ts16_byte[e1_alarm_pkg::DMA_BIT];
            end else if (st_ff.ts16_cnt != 4'h0) begin
                zacc = add_sat3(st_ff.sa_zeros, zeros_in(rx_ts16_byte));
                nxt_st.sa_zeros = zacc;
                nxt_st.sa_one = st_ff.sa_one | (|rx_ts16_byte);
                nxt_st.ts16_cnt = st_ff.ts16_cnt + 4'h1;
                if (st_ff.ts16_cnt == e1_alarm_pkg::MF_LAST) begin
                    nxt_st.sa1 = zacc < e1_alarm_pkg::MIN_ZEROS;
                    nxt_st.sa0 = !(st_ff.sa_one | (|rx_ts16_byte));
                end
            end
        end

        // Received bit stream: unframed all ones and carrier loss
        if (rx_bit_stb) begin
            zacc = add_sat3(st_ff.ua1_zeros, {3'h0, ~rx_bit});
            if (st_ff.ua1_cnt == e1_alarm_pkg::UA1_WIN_LAST) begin
                nxt_st.ua1 = zacc < e1_alarm_pkg::MIN_ZEROS;
                nxt_st.ua1_zeros = 2'h0;
                nxt_st.ua1_cnt = 9'h000;
            end else begin
                nxt_st.ua1_zeros = zacc;
                nxt_st.ua1_cnt = st_ff.ua1_cnt + 9'h001;
            end
            rcl_thr = st_ff.ctrl[e1_alarm_pkg::CTL_EXT_LOSS] ?
                e1_alarm_pkg::RCL_ZEROS_EXT : e1_alarm_pkg::RCL_ZEROS;
            if (rx_bit) begin
                nxt_st.rcl_zeros = 12'h000;
            end else if (st_ff.rcl_zeros < e1_alarm_pkg::RCL_ZEROS_EXT) begin
                nxt_st.rcl_zeros = st_ff.rcl_zeros + 12'h001;
            end
            if (!st_ff.carrier_loss_flag) begin
                nxt_st.carrier_loss_flag = nxt_st.rcl_zeros >= rcl_thr;
                nxt_st.rcl_win = 8'h00;
                nxt_st.rcl_ones = 6'h00;
            end else if (st_ff.rcl_ones + {5'h00, rx_bit} >= e1_alarm_pkg::RCL_ONES) begin
                nxt_st.carrier_loss_flag = 1'b0;
                nxt_st.rcl_win = 8'h00;
                nxt_st.rcl_ones = 6'h00;
            end else if (st_ff.rcl_win == e1_alarm_pkg::RCL_WIN_LAST) begin
                nxt_st.rcl_win = 8'h00;
                nxt_st.rcl_ones = 6'h00;
            end else begin
                nxt_st.rcl_win = st_ff.rcl_win + 8'h01;
                nxt_st.rcl_ones = st_ff.rcl_ones + {5'h00, rx_bit};
            end
            // Timer runs off received bits; >= lets a mode switch wrap at once
            if (st_ff.sec_cnt >= (st_ff.ctrl[e1_alarm_pkg::CTL_FAST] ? FAST_LAST : SEC_LAST))
            begin
                sec_tick = 1'b1;
                nxt_st.sec_cnt = '0;
            end else begin
                nxt_st.sec_cnt = st_ff.sec_cnt + SEC_W'(1);
            end
        end

        // Remote alarm from non-align frames
        if (rx_nonalign_stb) begin
            nxt_st.rra_ones = rx_remote_bit ? run_inc(st_ff.rra_ones) : 2'h0;
            nxt_st.rra_zeros = rx_remote_bit ? 2'h0 : run_inc(st_ff.rra_zeros);
            if (nxt_st.rra_ones == e1_alarm_pkg::RRA_RUN) begin
                nxt_st.remote_alarm_flag = 1'b1;
            end else if (nxt_st.rra_zeros == e1_alarm_pkg::RRA_RUN) begin
                nxt_st.remote_alarm_flag = 1'b0;
            end
        end

        // Free-running 16-frame boundary used while CRC4 is off
        if (rx_frame_stb) begin
            nxt_st.mf_cnt = st_ff.mf_cnt + 4'h1;
        end
        rx_crc_mf_flag_tick = st_ff.ctrl[e1_alarm_pkg::CTL_CRC_EN] ? rx_crc_mf_stb :
            (rx_frame_stb && st_ff.mf_cnt == e1_alarm_pkg::MF_LAST);

        // Transmit clock watchdog; the input is sampled, not a clock here
        nxt_st.tx_line_clock_prev = tx_line_clock;
        if (tx_line_clock != st_ff.tx_line_clock_prev) begin
            nxt_st.tx_clock_loss_flag_cnt = 6'h00;
            nxt_st.tx_clock_loss_flag = 1'b0;
        end else if (st_ff.tx_clock_loss_flag_cnt == e1_alarm_pkg::TX_CLOCK_LOSS_FLAG_LAST) begin
            nxt_st.tx_clock_loss_flag = 1'b1;
        end else begin
            nxt_st.tx_clock_loss_flag_cnt = st_ff.tx_clock_loss_flag_cnt + 6'h01;
        end

        nxt_st.los = !rx_in_sync;

        // Receive alarm status: live levels plus slip and change pulses
        set1[e1_alarm_pkg::B_SA1] = nxt_st.sa1 | sig_change_stb;
        set1[e1_alarm_pkg::B_DMA] = nxt_st.dma;
        set1[e1_alarm_pkg::B_SA0] = nxt_st.sa0 | sig_change_stb;
        set1[e1_alarm_pkg::B_RX_SLIP_FLAG] = rx_slip_stb;
        set1[e1_alarm_pkg::B_UA1] = nxt_st.ua1;
        set1[e1_alarm_pkg::B_RRA] = nxt_st.remote_alarm_flag;
        set1[e1_alarm_pkg::B_RCL] = nxt_st.carrier_loss_flag;
        set1[e1_alarm_pkg::B_LOS] = nxt_st.los;
        chg1 = {nxt_st.sa1 ^ st_ff.sa1, nxt_st.dma ^ st_ff.dma, nxt_st.sa0 ^ st_ff.sa0,
            1'b0, nxt_st.ua1 ^ st_ff.ua1, nxt_st.remote_alarm_flag ^ st_ff.remote_alarm_flag,
            nxt_st.carrier_loss_flag ^ st_ff.carrier_loss_flag, nxt_st.los ^ st_ff.los};
        irq1 = (chg1 & e1_alarm_pkg::ALARM_KIND)
            | (chg1 & set1 & ~e1_alarm_pkg::ALARM_KIND)
            | (set1 & ~e1_alarm_pkg::ALARM_KIND & ~{1'b0, nxt_st.dma, 6'h00}
            & ~{nxt_st.sa1, 1'b0, nxt_st.sa0, 5'h00});

        // Event status
        set2[e1_alarm_pkg::E_RMF] = rx_cas_mf_stb;
        set2[e1_alarm_pkg::E_RAF] = rx_align_stb;
        set2[e1_alarm_pkg::E_TMF] = tx_mf_stb;
        set2[e1_alarm_pkg::E_SEC] = sec_tick;
        set2[e1_alarm_pkg::E_TAF] = tx_align_stb;
        set2[e1_alarm_pkg::E_TX_CLOCK_LOSS_FLAG] = nxt_st.tx_clock_loss_flag;
        set2[e1_alarm_pkg::E_RX_CRC_MF_FLAG] = rx_crc_mf_flag_tick;
        set2[e1_alarm_pkg::E_TX_SLIP_FLAG] = tx_slip_stb;
        irq2 = set2;
        irq2[e1_alarm_pkg::E_TX_CLOCK_LOSS_FLAG] = nxt_st.tx_clock_loss_flag & ~st_ff.tx_clock_loss_flag;

        // A read clears the whole register; a new set in that cycle wins
        nxt_st.alarm_st = (rd_alarm ? 8'h00 : st_ff.alarm_st) | set1;
        nxt_st.event_st = (rd_event ? 8'h00 : st_ff.event_st) | set2;
        nxt_st.pend1 = (rd_alarm ? 8'h00 : st_ff.pend1) | irq1;
        nxt_st.pend2 = (rd_event ? 8'h00 : st_ff.pend2) | irq2;

        // Register writes
        if (wr_stb) begin
            unique case (addr)
                e1_alarm_pkg::A_MASK1: nxt_st.mask1 = wr_data;
                e1_alarm_pkg::A_MASK2: nxt_st.mask2 = wr_data;
                e1_alarm_pkg::A_CTRL: nxt_st.ctrl = wr_data[3:0];
                default: ;
            endcase
        end

        // Read data stands only in the cycle after the strobe
        nxt_st.rd_data = 8'h00;
        if (rd_stb) begin
            unique case (addr)
                e1_alarm_pkg::A_ALARM: nxt_st.rd_data = st_ff.alarm_st;
                e1_alarm_pkg::A_EVENT: nxt_st.rd_data = st_ff.event_st;
                e1_alarm_pkg::A_MASK1: nxt_st.rd_data = st_ff.mask1;
                e1_alarm_pkg::A_MASK2: nxt_st.rd_data = st_ff.mask2;
                e1_alarm_pkg::A_SYNC: nxt_st.rd_data = {st_ff.crc_cnt[5:2],
                    st_ff.crc_cnt[0], 3'h0};
                e1_alarm_pkg::A_CTRL: nxt_st.rd_data = {4'h0, st_ff.ctrl};
                default: nxt_st.rd_data = 8'h00;
            endcase
        end

        // Outputs registered from next state so they track status exactly
        nxt_st.int_n = ~|{nxt_st.pend1 & nxt_st.mask1,
            nxt_st.pend2 & nxt_st.mask2};
        nxt_st.loss_pin = nxt_st.tx_clock_loss_flag & nxt_st.ctrl[e1_alarm_pkg::CTL_PIN_EN];
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{int_n: 1'b1, mask1: e1_alarm_pkg::MASK_RESET,
                mask2: e1_alarm_pkg::MASK_RESET, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data = st_ff.rd_data;
    assign int_n = st_ff.int_n;
    assign clock_loss_pin = st_ff.loss_pin;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_crc_inc;
        crc_search_timeout_stb && !crc_sync_stb && st_ff.ctrl[e1_alarm_pkg::CTL_CRC_EN]
            && !wr_stb |=> st_ff.crc_cnt == $past(st_ff.crc_cnt) + 6'h01;
    endproperty
    a_crc_inc: assert property (p_crc_inc) else $error("search count missed a step");

    property p_crc_sync;
        crc_sync_stb |=> st_ff.crc_cnt == 6'h00;
    endproperty
    a_crc_sync: assert property (p_crc_sync) else $error("count not cleared on sync");

    property p_crc_off;
        !st_ff.ctrl[e1_alarm_pkg::CTL_CRC_EN] |=> st_ff.crc_cnt == 6'h00;
    endproperty
    a_crc_off: assert property (p_crc_off) else $error("count alive with mode off");

    property p_crc_wrap;
        crc_search_timeout_stb && !crc_sync_stb && st_ff.crc_cnt == 6'h3f
            && st_ff.ctrl[e1_alarm_pkg::CTL_CRC_EN] && !wr_stb |=> st_ff.crc_cnt == 6'h00;
    endproperty
    a_crc_wrap: assert property (p_crc_wrap) else $error("count did not wrap");

    property p_sig_change;
        sig_change_stb |=> st_ff.alarm_st[e1_alarm_pkg::B_SA1]
            && st_ff.alarm_st[e1_alarm_pkg::B_SA0];
    endproperty
    a_sig_change: assert property (p_sig_change) else $error("change set one flag");

    sequence s_slip_unread;
        rx_slip_stb ##1 !(rd_stb && addr == e1_alarm_pkg::A_ALARM) [*3];
    endsequence
    property p_slip_held;
        s_slip_unread |-> st_ff.alarm_st[e1_alarm_pkg::B_RX_SLIP_FLAG];
    endproperty
    a_slip_held: assert property (p_slip_held) else $error("slip flag lost");

    property p_tx_slip;
        tx_slip_stb |=> st_ff.event_st[e1_alarm_pkg::E_TX_SLIP_FLAG];
    endproperty
    a_tx_slip: assert property (p_tx_slip) else $error("transmit slip not flagged");

    property p_los;
        !rx_in_sync [*2] |-> st_ff.alarm_st[e1_alarm_pkg::B_LOS];
    endproperty
    a_los: assert property (p_los) else $error("sync loss not shown");

    property p_alarm_irq;
        $changed(st_ff.ua1) && st_ff.mask1[e1_alarm_pkg::B_UA1] |-> !int_n;
    endproperty
    a_alarm_irq: assert property (p_alarm_irq) else $error("alarm change no interrupt");

    property p_event_irq;
        rx_align_stb && st_ff.mask2[e1_alarm_pkg::E_RAF] && !wr_stb |=> !int_n;
    endproperty
    a_event_irq: assert property (p_event_irq) else $error("event gave no interrupt");

    property p_masked;
        st_ff.mask1 == 8'h00 && st_ff.mask2 == 8'h00 && !wr_stb |=> int_n;
    endproperty
    a_masked: assert property (p_masked) else $error("masked flag reached interrupt");

    property p_loss_pin;
        $rose(st_ff.tx_clock_loss_flag) |-> st_ff.event_st[e1_alarm_pkg::E_TX_CLOCK_LOSS_FLAG]
            && clock_loss_pin == st_ff.ctrl[e1_alarm_pkg::CTL_PIN_EN]
            && $stable(tx_line_clock);
    endproperty
    a_loss_pin: assert property (p_loss_pin) else $error("clock loss not reported");

endmodule

`default_nettype wire

// *** dv/line_source.sv ***
`default_nettype none

module line_source (
    // Clock and bench controls
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic zeros,
    input wire logic tx_run,
    // Line side toward the monitor
    output logic bit_stb,
    output logic bit_val,
    output logic tx_clk
);
    timeunit 1ns;
    timeprecision 1ns;

    // One bit per cycle; alternating data keeps both line detectors quiet
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bit_stb <= 1'b0;
            bit_val <= 1'b0;
            tx_clk <= 1'b0;
        end else begin
            bit_stb <= run;
            bit_val <= zeros ? 1'b0 : ~bit_val;
            tx_clk <= tx_run ? ~tx_clk : tx_clk;
        end
    end
endmodule

`default_nettype wire

// *** dv/e1_alarm_status_monitor_test.sv ***
`default_nettype none

module e1_alarm_status_monitor_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, in_sync = 1'b1;
    logic run = 1'b0, zeros = 1'b0, tx_run = 1'b1, bit_stb, bit_val, tx_clk, int_n, pin;
    logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data;
    logic [10:0] ev = 11'h000;
    logic na_stb = 1'b0, na_bit = 1'b0;
    // Strobe pattern, register, expected read value
    logic [26:0] rows [7] = '{{11'h001, 8'h06, 8'h10}, {11'h002, 8'h07, 8'h80},
        {11'h004, 8'h07, 8'h40}, {11'h008, 8'h07, 8'h20}, {11'h010, 8'h07, 8'h08},
        {11'h020, 8'h07, 8'h01}, {11'h080, 8'h06, 8'ha0}};
    int err_count = 0, comparisons = 0;

    always #50 ref_clk = ~ref_clk;

    line_source i_line_source (.ref_clk(ref_clk), .rst(rst), .run(run), .zeros(zeros),
        .tx_run(tx_run), .bit_stb(bit_stb), .bit_val(bit_val), .tx_clk(tx_clk));

    // Short counts so the timer ticks within a few dozen bits
    e1_alarm_status_monitor #(.SEC_BITS(64), .FAST_BITS(16)) i_e1_alarm_status_monitor (
        .ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data(rd_data), .rx_bit_stb(bit_stb), .rx_bit(bit_val),
        .rx_frame_stb(ev[10]), .rx_align_stb(ev[2]), .rx_ts16_stb(1'b0),
        .rx_ts16_byte(8'h00), .rx_ts16_frame0(1'b0), .rx_nonalign_stb(na_stb),
        .rx_remote_bit(na_bit), .rx_in_sync(in_sync), .sig_change_stb(ev[7]),
        .rx_cas_mf_stb(ev[1]), .rx_crc_mf_stb(ev[6]), .crc_search_timeout_stb(ev[8]),
        .crc_sync_stb(ev[9]), .rx_slip_stb(ev[0]), .tx_line_clock(tx_clk),
        .tx_align_stb(ev[4]), .tx_mf_stb(ev[3]), .tx_slip_stb(ev[5]), .int_n(int_n),
        .clock_loss_pin(pin));

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1 chk(rd_data, e);
    endtask

    task automatic pulse(input logic [10:0] v, input int n);
        repeat (n) begin
            ev <= v;
            @(posedge ref_clk);
            ev <= 11'h000;
            @(posedge ref_clk);
        end
    endtask

    // Three non-align frames carrying the same remote bit
    task automatic remote(input logic b);
        na_bit <= b;
        repeat (3) begin
            na_stb <= 1'b1;
            @(posedge ref_clk);
            na_stb <= 1'b0;
            @(posedge ref_clk);
        end
    endtask

    task automatic ck_int(input logic e);
        repeat (2) @(posedge ref_clk);
        #1 chk({7'h00, int_n}, {7'h00, e});
    endtask

    task automatic test_done;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Whole run is near 1300 cycles; give it 5000
    initial begin
        #500000;
        err_count++;
        test_done;
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1 chk({7'h00, int_n}, 8'h01);
        rd(e1_alarm_pkg::A_CTRL, 8'h00);
        rd(e1_alarm_pkg::A_MASK2, e1_alarm_pkg::MASK_RESET);
        rd(8'h55, 8'h00);
        wr(e1_alarm_pkg::A_ALARM, 8'hff);
        foreach (rows[i]) begin
            pulse(rows[i][26:16], 1);
            rd(rows[i][15:8], rows[i][7:0]);
            rd(rows[i][15:8], 8'h00);
        end
        wr(e1_alarm_pkg::A_MASK2, 8'h40);
        pulse(11'h004, 1);
        ck_int(1'b0);
        rd(e1_alarm_pkg::A_EVENT, 8'h40);
        ck_int(1'b1);
        wr(e1_alarm_pkg::A_MASK2, 8'h00);
        pulse(11'h008, 1);
        ck_int(1'b1);
        rd(e1_alarm_pkg::A_EVENT, 8'h20);
        wr(e1_alarm_pkg::A_MASK1, 8'h01);
        in_sync <= 1'b0;
        ck_int(1'b0);
        rd(e1_alarm_pkg::A_ALARM, 8'h01);
        ck_int(1'b1);
        in_sync <= 1'b1;
        ck_int(1'b0);
        rd(e1_alarm_pkg::A_ALARM, 8'h01);
        rd(e1_alarm_pkg::A_ALARM, 8'h00);
        remote(1'b1);
        rd(e1_alarm_pkg::A_ALARM, 8'h04);
        remote(1'b0);
        rd(e1_alarm_pkg::A_ALARM, 8'h04);
        rd(e1_alarm_pkg::A_ALARM, 8'h00);
        wr(e1_alarm_pkg::A_CTRL, 8'h01);
        pulse(11'h100, 3);
        rd(e1_alarm_pkg::A_SYNC, 8'h08);
        pulse(11'h200, 1);
        rd(e1_alarm_pkg::A_SYNC, 8'h00);
        pulse(11'h100, 65);
        rd(e1_alarm_pkg::A_SYNC, 8'h08);
        pulse(11'h040, 1);
        rd(e1_alarm_pkg::A_EVENT, 8'h02);
        wr(e1_alarm_pkg::A_CTRL, 8'h00);
        rd(e1_alarm_pkg::A_SYNC, 8'h00);
        pulse(11'h400, 16);
        rd(e1_alarm_pkg::A_EVENT, 8'h02);
        run <= 1'b1;
        repeat (70) @(posedge ref_clk);
        run <= 1'b0;
        rd(e1_alarm_pkg::A_EVENT, 8'h10);
        wr(e1_alarm_pkg::A_CTRL, 8'h02);
        run <= 1'b1;
        repeat (20) @(posedge ref_clk);
        zeros <= 1'b1;
        repeat (270) @(posedge ref_clk);
        zeros <= 1'b0;
        rd(e1_alarm_pkg::A_ALARM, 8'h02);
        repeat (330) @(posedge ref_clk);
        rd(e1_alarm_pkg::A_ALARM, 8'h02);
        rd(e1_alarm_pkg::A_ALARM, 8'h00);
        wr(e1_alarm_pkg::A_CTRL, 8'h04);
        zeros <= 1'b1;
        repeat (300) @(posedge ref_clk);
        zeros <= 1'b0;
        rd(e1_alarm_pkg::A_ALARM, 8'h00);
        run <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd(e1_alarm_pkg::A_EVENT, 8'h10);
        wr(e1_alarm_pkg::A_CTRL, 8'h08);
        tx_run <= 1'b0;
        repeat (45) @(posedge ref_clk);
        #1 chk({7'h00, pin}, 8'h01);
        rd(e1_alarm_pkg::A_EVENT, 8'h04);
        test_done;
    end
endmodule

`default_nettype wire
